// >>> bench/sct_bus_model.sv
// Protocol engine and bus side model for the state code tracker
`timescale 1ns/1ns
module sct_bus_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic ev_ready,
	input wire logic scl_low,
	output logic ev_valid,
	output logic [7:0] ev_word,
	output logic scl,
	output logic idle
);
	// ==========================================
	// Event queue, each word held until taken
	logic [7:0] q[$];
	logic taken;
	initial begin
		ev_valid = 1'b0;
		ev_word = 8'h00;
		idle = 1'b1;
	end
	task put(input logic [7:0] w);
		q.push_back(w);
	endtask : put
	always @(posedge clk) begin
		taken = ev_valid && ev_ready;
		#1;
		if (taken)
			void'(q.pop_front());
		ev_valid = !reset && q.size() != 0;
		// Released word flips to its inverse on every idle clock
		ev_word = ev_valid ? q[0] : ~ev_word;
		idle = !ev_valid && q.size() == 0;
	end
	// ==========================================
	// Clock line with pull-up
	assign scl = !scl_low;
endmodule : sct_bus_model

// >>> bench/smbus_status_code_tracker_test.sv
// Self-checking bench for the bus state code tracker
`timescale 1ns/1ns
module smbus_status_code_tracker_test;
	// ==========================================
	// Signals, counters and event table
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic [7:0] SFR_ADDR = 8'h00;
	logic SFR_WR = 1'b0;
	logic SFR_RD = 1'b0;
	logic [7:0] SFR_WDATA = 8'h00;
	logic [7:0] SFR_RDATA;
	logic EV_VALID, EV_READY, SCL_IN, START_REQ, STOP_REQ;
	logic ACK_ASSERT, SLAVE_RELEASE, EVENT_FLAG, idle;
	logic [7:0] EV_WORD;
	logic scl_low = 1'b0;
	logic [7:0] ctl = 8'h44;
	logic [7:0] rv;
	logic [31:0] seed = 32'h2a8374f5;
	int error_cnt = 0;
	int tests_run = 0;
	localparam logic [15:0] SEQ [54] = '{
		16'h0008, 16'h1118, 16'h1228, 16'h0230, 16'h06f8,
		16'h0008, 16'h0120, 16'hfe74, 16'h06f8, 16'hfe44,
		16'h0008, 16'h0010, 16'h3140, 16'h1350, 16'hfe40, 16'h0358, 16'hfe44, 16'h06f8,
		16'h0008, 16'h2148, 16'h06f8,
		16'h0008, 16'h0438, 16'h1560, 16'h1380, 16'h0388, 16'hff01,
		16'h5570, 16'h1390, 16'h0398, 16'hff01,
		16'h35a8, 16'h12b8, 16'h02c0, 16'h06a0,
		16'h0008, 16'h9568, 16'h06a0,
		16'h0008, 16'hd578, 16'h06a0,
		16'h0008, 16'hb5b0, 16'hfe40, 16'h12c8, 16'hfe44, 16'hff01,
		16'hfe46, 16'h0008, 16'hfdd0, 16'hfe44, 16'hff00,
		16'h0700, 16'hff00
	};
	sct_tracker sct_tracker_inst (.CLK(CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
		.SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
		.EV_VALID(EV_VALID), .EV_READY(EV_READY), .EV_WORD(EV_WORD), .SCL_IN(SCL_IN),
		.START_REQ(START_REQ), .STOP_REQ(STOP_REQ), .ACK_ASSERT(ACK_ASSERT),
		.SLAVE_RELEASE(SLAVE_RELEASE), .EVENT_FLAG(EVENT_FLAG));
	sct_bus_model sct_bus_model_inst (.clk(CLK), .reset(RESET), .ev_ready(EV_READY),
		.scl_low(scl_low), .ev_valid(EV_VALID), .ev_word(EV_WORD), .scl(SCL_IN),
		.idle(idle));
	always #2 CLK = ~CLK;
	// ==========================================
	// Helpers
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic logic [7:0] status_view(input logic [7:0] code);
		return {code[7:3], 3'b000};
	endfunction : status_view
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1'b1;
		tick(1);
		SFR_WR = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		tick(1);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		tick(1);
		SFR_RD = 1'b0;
		d = SFR_RDATA;
	endtask : rd
	task automatic wait_flag();
		int n;
		n = 0;
		while (EVENT_FLAG !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		if (n == 300) begin
			error_cnt++;
			give_verdict();
		end
	endtask : wait_flag
	task automatic wait_idle();
		int n;
		n = 0;
		tick(1);
		while (idle !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		if (n == 300) begin
			error_cnt++;
			give_verdict();
		end
	endtask : wait_idle
	// ==========================================
	// One table step: event, control change or stop request
	task automatic step(input logic [15:0] e);
		int n;
		logic [7:0] w;
		logic [7:0] x;
		w = e[15:8];
		x = e[7:0];
		if (w == 8'hfe) begin
			ctl = x;
			wr(8'hc0, ctl);
			tick(1);
			chk("ack_assert", {7'h0, ACK_ASSERT}, {7'h0, ctl[2]});
			chk("start_req", {7'h0, START_REQ}, {7'h0, ctl[5]});
		end else if (w == 8'hff) begin
			wr(8'hc0, ctl | 8'h10);
			n = 0;
			repeat (8) begin
				if (SLAVE_RELEASE === 1'b1)
					n++;
				tick(1);
			end
			if (x[0])
				chk("release", n[7:0], 8'h01);
			chk("stop_req", {7'h0, STOP_REQ}, {7'h0, !x[0]});
		end else begin
			if (w != 8'hfd) begin
				sct_bus_model_inst.put(w);
			end else begin
				// Clock held low stops the timer
				scl_low = 1'b1;
				tick(60);
				chk("no timeout while low", {7'h0, EVENT_FLAG}, 8'h00);
				scl_low = 1'b0;
			end
			if (x == 8'hf8) begin
				wait_idle();
				tick(4);
				chk("idle flag", {7'h0, EVENT_FLAG}, 8'h00);
				rd(8'hc1, rv);
				chk("idle code", rv, 8'hf8);
			end else begin
				wait_flag();
				tick(3);
				chk("flag held", {7'h0, EVENT_FLAG}, 8'h01);
				rd(8'hc1, rv);
				chk("code", rv, status_view(x));
				wr(8'hc0, ctl);
				chk("flag clear", {7'h0, EVENT_FLAG}, 8'h00);
			end
		end
	endtask : step
	// ==========================================
	// Main sequence
	initial begin
		tick(6);
		RESET = 1'b0;
		rd(8'hc1, rv);
		chk("status reset", rv, 8'hf8);
		rd(8'hc0, rv);
		chk("control reset", rv, 8'h00);
		rd(8'hcf, rv);
		chk("rate reset", rv, sct_pkg::RATE_RST);
		rd(8'h55, rv);
		chk("unmapped", rv, 8'h00);
		wr(8'hc1, 8'h5a);
		rd(8'hc1, rv);
		chk("status after write", rv, 8'hf8);
		wr(8'hcf, 8'hfc);
		rd(8'hcf, rv);
		chk("rate", rv, 8'hfc);
		wr(8'hc0, ctl);
		for (int i = 0; i < 54; i++)
			step(SEQ[i]);
		// Buffer filled while flag stalls, then drained disabled
		sct_bus_model_inst.put(8'h07);
		wait_flag();
		for (int i = 0; i < 20; i++) begin
			seed = xorshift(seed);
			sct_bus_model_inst.put(seed[7:0]);
		end
		tick(40);
		chk("buffer full", {7'h0, EV_READY}, 8'h00);
		wr(8'hc0, 8'h04);
		wait_idle();
		tick(2);
		chk("buffer drained", {7'h0, EV_READY}, 8'h01);
		chk("flag disabled", {7'h0, EVENT_FLAG}, 8'h00);
		RESET = 1'b1;
		tick(2);
		RESET = 1'b0;
		chk("flag after reset", {7'h0, EVENT_FLAG}, 8'h00);
		rd(8'hc1, rv);
		chk("status second reset", rv, 8'hf8);
		give_verdict();
	end
endmodule : smbus_status_code_tracker_test

// >>> rtl/sct_fifo.sv
// Event FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sct_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pull;

	assign in_ready = cnt_r != DEPTH[AW:0];
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pull = out_valid && out_ready;

	// ==========================================
	// Pointers and storage
	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt = wp_r + 1'b1;
		end
		if (pull) begin
			rp_nxt = rp_r + 1'b1;
		end
		if (push && !pull) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pull && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		mem_r <= mem_nxt;
		if (reset) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : sct_fifo

// >>> rtl/sct_free_timer.sv
// Clock-high timer preloaded from the rate preset
`timescale 1ns/1ns
module sct_free_timer (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [7:0] preset,
	output logic expire
);
	logic [7:0] cnt_r, cnt_nxt;
	logic [3:0] rolls_r, rolls_nxt;
	logic done_r, done_nxt;
	logic fire_r, fire_nxt;

	assign expire = fire_r;

	// ==========================================
	// Ten rollovers of the preset counter
	always_comb begin
		cnt_nxt = cnt_r;
		rolls_nxt = rolls_r;
		done_nxt = done_r;
		fire_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = preset;
			rolls_nxt = '0;
			done_nxt = 1'b0;
		end else if (!done_r) begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == 8'hff) begin
				cnt_nxt = preset;
				rolls_nxt = rolls_r + 1'b1;
				if (rolls_r == sct_pkg::TMR_ROLLS - 4'h1) begin
					done_nxt = 1'b1;
					fire_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= sct_pkg::RATE_RST;
			rolls_r <= '0;
			done_r <= 1'b0;
			fire_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rolls_r <= rolls_nxt;
			done_r <= done_nxt;
			fire_r <= fire_nxt;
		end
	end
endmodule : sct_free_timer

// >>> rtl/sct_pkg.sv
// Constants and types for the bus state code tracker
package sct_pkg;
	// ==========================================
	// Register map and reset values
	localparam logic [7:0] ADR_CTRL = 8'hc0;
	localparam logic [7:0] ADR_SMBUS_STATE_CODE = 8'hc1;
	localparam logic [7:0] ADR_RATE = 8'hcf;
	localparam logic [7:0] RATE_RST = 8'h00;
	// ==========================================
	// Control register bit positions
	localparam int CTL_BUSY = 7;
	localparam int CTL_EN = 6;
	localparam int CTL_START = 5;
	localparam int CTL_STOP = 4;
	localparam int CTL_FLAG = 3;
	localparam int CTL_ACK = 2;
	localparam int CTL_FTE = 1;
	localparam int CTL_TOE = 0;
	// ==========================================
	// State codes
	localparam logic [7:0] C_START = 8'h08;
	localparam logic [7:0] C_RSTART = 8'h10;
	localparam logic [7:0] C_AW_ACK = 8'h18;
	localparam logic [7:0] C_AW_NAK = 8'h20;
	localparam logic [7:0] C_DT_ACK = 8'h28;
	localparam logic [7:0] C_DT_NAK = 8'h30;
	localparam logic [7:0] C_ARB = 8'h38;
	localparam logic [7:0] C_AR_ACK = 8'h40;
	localparam logic [7:0] C_AR_NAK = 8'h48;
	localparam logic [7:0] C_DR_ACK = 8'h50;
	localparam logic [7:0] C_DR_NAK = 8'h58;
	localparam logic [7:0] C_SW = 8'h60;
	localparam logic [7:0] C_SW_ARB = 8'h68;
	localparam logic [7:0] C_GC = 8'h70;
	localparam logic [7:0] C_GC_ARB = 8'h78;
	localparam logic [7:0] C_SD_ACK = 8'h80;
	localparam logic [7:0] C_SD_NAK = 8'h88;
	localparam logic [7:0] C_GD_ACK = 8'h90;
	localparam logic [7:0] C_GD_NAK = 8'h98;
	localparam logic [7:0] C_SSTOP = 8'ha0;
	localparam logic [7:0] C_SR = 8'ha8;
	localparam logic [7:0] C_SR_ARB = 8'hb0;
	localparam logic [7:0] C_ST_ACK = 8'hb8;
	localparam logic [7:0] C_ST_NAK = 8'hc0;
	localparam logic [7:0] C_ST_LAST = 8'hc8;
	localparam logic [7:0] C_TMO = 8'hd0;
	localparam logic [7:0] C_BERR = 8'h00;
	localparam logic [7:0] C_IDLE = 8'hf8;
	// ==========================================
	// Event word layout and sizes
	localparam int EW_KIND = 0;
	localparam int EW_ACK = 4;
	localparam int EW_RW = 5;
	localparam int EW_GC = 6;
	localparam int EW_ARB = 7;
	localparam int EV_WIDTH = 8;
	localparam int EV_DEPTH = 16;
	localparam logic [3:0] TMR_ROLLS = 4'ha;
	// ==========================================
	// Types
	typedef enum logic [3:0] {
		EV_START = 4'h0,
		EV_ADDR_TX = 4'h1,
		EV_DATA_TX = 4'h2,
		EV_DATA_RX = 4'h3,
		EV_ARB = 4'h4,
		EV_ADDR_RX = 4'h5,
		EV_STOP = 4'h6,
		EV_BUS_ERR = 4'h7
	} sct_event_type;
	typedef enum logic [6:0] {
		M_IDLE = 7'b0000001,
		M_MST = 7'b0000010,
		M_MT = 7'b0000100,
		M_MR = 7'b0001000,
		M_SRX = 7'b0010000,
		M_SGC = 7'b0100000,
		M_STX = 7'b1000000
	} sct_mode_type;
endpackage : sct_pkg

// >>> rtl/sct_tracker.sv
// Bus state code tracker with control and state code registers
// Summary of operation
// - Five-bit code in status bits 7..3, 28 codes, one per state.
// - Status code valid only while the event flag is set.
// - Low three status bits read zero; codes are multiples of eight.
// - Idle code 0xF8 never sets the flag; status resets to it.
// - Master reports 0x08 after START, 0x10 after repeated START.
// - Address plus write: 0x18 on ACK, 0x20 on NACK.
// - Master data sent: 0x28 on ACK, 0x30 on NACK.
// - Arbitration lost 0x38; lost then addressed gives 0x68, 0x78, 0xB0.
// - Address plus read: 0x40 on ACK, 0x48 on NACK.
// - Master receive 0x50 with ACK, 0x58 with NACK; software clears ack.
// - Own write address gives 0x60; general call gives 0x70.
// - Slave byte received: 0x80 with ACK, 0x88 with NACK.
// - General call byte: 0x90 with ACK, 0x98 with NACK.
// - Addressed slave seeing STOP reports 0xA0; a START there reports 0x08.
// - Slave transmit: 0xA8 own read, 0xB8 byte ACK, 0xC0 byte NACK.
// - Slave last byte with ack flag clear yet ACKed reports 0xC8.
// - Clock-high timer expiry from rate preset reports 0xD0.
// - Illegal START or STOP reports bus error 0x00.
// - Event flag set on every reporting state, cleared only by software.
// - Ack flag selects ACK or NACK in every owned acknowledge cycle.
// - Stop request in slave mode acts as received STOP, releasing bus.
`timescale 1ns/1ns
module sct_tracker (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic EV_VALID,
	output logic EV_READY,
	input wire logic [7:0] EV_WORD,
	input wire logic SCL_IN,
	output logic START_REQ,
	output logic STOP_REQ,
	output logic ACK_ASSERT,
	output logic SLAVE_RELEASE,
	output logic EVENT_FLAG
);
	sct_pkg::sct_mode_type mode_r, mode_nxt;
	logic [7:0] code_r, code_nxt;
	logic flag_r, flag_nxt;
	logic en_r, en_nxt;
	logic start_request_flag_r, start_nxt;
	logic stop_request_flag_r, stop_nxt;
	logic ack_assert_flag_r, ack_nxt;
	logic fte_r, fte_nxt;
	logic toe_r, toe_nxt;
	logic [7:0] rate_r, rate_nxt;
	logic tmo_r, tmo_nxt;
	logic rel_r, rel_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic scl_s1_r, scl_s2_r;
	logic ev_valid, pop, tmo_fire, tmo_take, slv_stop, ctl_wr;
	logic [7:0] ev_word;
	logic [3:0] ev_kind;
	logic ev_ack, ev_rw, ev_gc, ev_arb;
	logic rep;
	logic [7:0] code;

	function automatic logic is_master(input sct_pkg::sct_mode_type m);
		return m == sct_pkg::M_MST || m == sct_pkg::M_MT || m == sct_pkg::M_MR;
	endfunction : is_master

	function automatic logic is_slave(input sct_pkg::sct_mode_type m);
		return m == sct_pkg::M_SRX || m == sct_pkg::M_SGC || m == sct_pkg::M_STX;
	endfunction : is_slave

	// ==========================================
	// Event queue and clock-high timer
	sct_fifo #(
		.WIDTH(sct_pkg::EV_WIDTH),
		.DEPTH(sct_pkg::EV_DEPTH)
	) u_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(EV_VALID),
		.in_ready(EV_READY),
		.in_data(EV_WORD),
		.out_valid(ev_valid),
		.out_ready(pop),
		.out_data(ev_word)
	);

	sct_free_timer u_timer (
		.clk(CLK),
		.reset(RESET),
		.run(scl_s2_r && fte_r && en_r && mode_r != sct_pkg::M_IDLE),
		.preset(rate_r),
		.expire(tmo_fire)
	);

	assign ev_kind = ev_word[sct_pkg::EW_KIND+:4];
	assign ev_ack = ev_word[sct_pkg::EW_ACK];
	assign ev_rw = ev_word[sct_pkg::EW_RW];
	assign ev_gc = ev_word[sct_pkg::EW_GC];
	assign ev_arb = ev_word[sct_pkg::EW_ARB];
	assign ctl_wr = SFR_WR && SFR_ADDR == sct_pkg::ADR_CTRL;
	assign slv_stop = stop_request_flag_r && is_slave(mode_r);
	assign tmo_take = tmo_r && !flag_r && en_r && !slv_stop;
	assign pop = ev_valid && (!en_r || (!flag_r && !slv_stop && !tmo_take));

	assign SFR_RDATA = rdata_r;
	assign START_REQ = start_request_flag_r;
	assign STOP_REQ = stop_request_flag_r;
	assign ACK_ASSERT = ack_assert_flag_r;
	assign SLAVE_RELEASE = rel_r;
	assign EVENT_FLAG = flag_r;

	// ==========================================
	// Control flags and state code
	always_comb begin
		rep = 1'b0;
		code = code_r;
		mode_nxt = mode_r;
		code_nxt = code_r;
		flag_nxt = flag_r;
		en_nxt = en_r;
		start_nxt = start_request_flag_r;
		stop_nxt = stop_request_flag_r;
		ack_nxt = ack_assert_flag_r;
		fte_nxt = fte_r;
		toe_nxt = toe_r;
		rate_nxt = rate_r;
		tmo_nxt = tmo_r || tmo_fire;
		rel_nxt = 1'b0;
		if (ctl_wr) begin
			en_nxt = SFR_WDATA[sct_pkg::CTL_EN];
			start_nxt = SFR_WDATA[sct_pkg::CTL_START];
			stop_nxt = SFR_WDATA[sct_pkg::CTL_STOP];
			flag_nxt = SFR_WDATA[sct_pkg::CTL_FLAG];
			ack_nxt = SFR_WDATA[sct_pkg::CTL_ACK];
			fte_nxt = SFR_WDATA[sct_pkg::CTL_FTE];
			toe_nxt = SFR_WDATA[sct_pkg::CTL_TOE];
		end
		if (SFR_WR && SFR_ADDR == sct_pkg::ADR_RATE) begin
			rate_nxt = SFR_WDATA;
		end
		if (slv_stop) begin
			mode_nxt = sct_pkg::M_IDLE;
			stop_nxt = 1'b0;
			rel_nxt = 1'b1;
		end else if (tmo_take) begin
			rep = 1'b1;
			code = sct_pkg::C_TMO;
			tmo_nxt = 1'b0;
		end else if (pop && en_r) begin
			case (ev_kind)
				sct_pkg::EV_START: begin
					rep = 1'b1;
					code = is_master(mode_r) ? sct_pkg::C_RSTART : sct_pkg::C_START;
					mode_nxt = sct_pkg::M_MST;
				end
				sct_pkg::EV_ADDR_TX: begin
					rep = 1'b1;
					if (ev_rw) begin
						code = ev_ack ? sct_pkg::C_AR_ACK : sct_pkg::C_AR_NAK;
						mode_nxt = sct_pkg::M_MR;
					end else begin
						code = ev_ack ? sct_pkg::C_AW_ACK : sct_pkg::C_AW_NAK;
						mode_nxt = sct_pkg::M_MT;
					end
				end
				sct_pkg::EV_DATA_TX: begin
					rep = 1'b1;
					if (mode_r == sct_pkg::M_STX) begin
						if (!ev_ack) begin
							code = sct_pkg::C_ST_NAK;
						end else begin
							code = ack_assert_flag_r ? sct_pkg::C_ST_ACK : sct_pkg::C_ST_LAST;
						end
					end else begin
						code = ev_ack ? sct_pkg::C_DT_ACK : sct_pkg::C_DT_NAK;
					end
				end
				sct_pkg::EV_DATA_RX: begin
					rep = 1'b1;
					case (mode_r)
						sct_pkg::M_SRX: code = ev_ack ? sct_pkg::C_SD_ACK : sct_pkg::C_SD_NAK;
						sct_pkg::M_SGC: code = ev_ack ? sct_pkg::C_GD_ACK : sct_pkg::C_GD_NAK;
						default: code = ev_ack ? sct_pkg::C_DR_ACK : sct_pkg::C_DR_NAK;
					endcase
				end
				sct_pkg::EV_ARB: begin
					rep = 1'b1;
					code = sct_pkg::C_ARB;
					mode_nxt = sct_pkg::M_IDLE;
				end
				sct_pkg::EV_ADDR_RX: begin
					rep = 1'b1;
					if (ev_gc) begin
						code = ev_arb ? sct_pkg::C_GC_ARB : sct_pkg::C_GC;
						mode_nxt = sct_pkg::M_SGC;
					end else if (ev_rw) begin
						code = ev_arb ? sct_pkg::C_SR_ARB : sct_pkg::C_SR;
						mode_nxt = sct_pkg::M_STX;
					end else begin
						code = ev_arb ? sct_pkg::C_SW_ARB : sct_pkg::C_SW;
						mode_nxt = sct_pkg::M_SRX;
					end
				end
				sct_pkg::EV_STOP: begin
					stop_nxt = ctl_wr && SFR_WDATA[sct_pkg::CTL_STOP]; // Software set wins
					mode_nxt = sct_pkg::M_IDLE;
					if (is_slave(mode_r)) begin
						rep = 1'b1;
						code = sct_pkg::C_SSTOP;
					end else begin
						code_nxt = sct_pkg::C_IDLE;
					end
				end
				sct_pkg::EV_BUS_ERR: begin
					rep = 1'b1;
					code = sct_pkg::C_BERR;
					mode_nxt = sct_pkg::M_IDLE;
				end
				default: begin
				end
			endcase
		end
		if (!en_r) begin
			mode_nxt = sct_pkg::M_IDLE;
		end
		if (rep) begin
			flag_nxt = 1'b1;
			code_nxt = code;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			mode_r <= sct_pkg::M_IDLE;
			code_r <= sct_pkg::C_IDLE;
			flag_r <= 1'b0;
			en_r <= 1'b0;
			start_request_flag_r <= 1'b0;
			stop_request_flag_r <= 1'b0;
			ack_assert_flag_r <= 1'b0;
			fte_r <= 1'b0;
			toe_r <= 1'b0;
			rate_r <= sct_pkg::RATE_RST;
			tmo_r <= 1'b0;
			rel_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			code_r <= code_nxt;
			flag_r <= flag_nxt;
			en_r <= en_nxt;
			start_request_flag_r <= start_nxt;
			stop_request_flag_r <= stop_nxt;
			ack_assert_flag_r <= ack_nxt;
			fte_r <= fte_nxt;
			toe_r <= toe_nxt;
			rate_r <= rate_nxt;
			tmo_r <= tmo_nxt;
			rel_r <= rel_nxt;
		end
	end

	// ==========================================
	// Register reads and pin synchroniser
	always_comb begin
		rdata_nxt = rdata_r;
		if (SFR_RD) begin
			case (SFR_ADDR)
				sct_pkg::ADR_CTRL: rdata_nxt = {mode_r != sct_pkg::M_IDLE, en_r,
					start_request_flag_r, stop_request_flag_r, flag_r,
					ack_assert_flag_r, fte_r, toe_r};
				sct_pkg::ADR_SMBUS_STATE_CODE: rdata_nxt = {code_r[7:3], 3'h0};
				sct_pkg::ADR_RATE: rdata_nxt = rate_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rdata_r <= 8'h00;
			scl_s1_r <= 1'b0;
			scl_s2_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			scl_s1_r <= SCL_IN;
			scl_s2_r <= scl_s1_r;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	sequence s_pop(logic [3:0] k);
		pop && en_r && !slv_stop && !tmo_take && ev_kind == k;
	endsequence

	property p_low_zero;
		SFR_RD && SFR_ADDR == sct_pkg::ADR_SMBUS_STATE_CODE |=> SFR_RDATA[2:0] == 3'h0;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("status low bits not zero");

	property p_idle_no_flag;
		$rose(flag_r) |-> code_r != sct_pkg::C_IDLE;
	endproperty
	a_idle_no_flag: assert property (p_idle_no_flag) else $error("idle code raised flag");

	property p_start;
		s_pop(sct_pkg::EV_START) ##0 !is_master(mode_r) |=> code_r == sct_pkg::C_START && flag_r;
	endproperty
	a_start: assert property (p_start) else $error("start code wrong");

	property p_rstart;
		s_pop(sct_pkg::EV_START) ##0 is_master(mode_r) |=> code_r == sct_pkg::C_RSTART;
	endproperty
	a_rstart: assert property (p_rstart) else $error("repeated start code wrong");

	property p_addr_w;
		s_pop(sct_pkg::EV_ADDR_TX) ##0 !ev_rw ##0 ev_ack |=> code_r == sct_pkg::C_AW_ACK
			##1 mode_r == sct_pkg::M_MT;
	endproperty
	a_addr_w: assert property (p_addr_w) else $error("address write ack code wrong");

	property p_arb;
		s_pop(sct_pkg::EV_ARB) |=> code_r == sct_pkg::C_ARB && mode_r == sct_pkg::M_IDLE;
	endproperty
	a_arb: assert property (p_arb) else $error("arbitration code wrong");

	property p_berr;
		s_pop(sct_pkg::EV_BUS_ERR) |=> code_r == sct_pkg::C_BERR && flag_r;
	endproperty
	a_berr: assert property (p_berr) else $error("bus error code wrong");

	property p_flag_hold;
		flag_r && !(ctl_wr && !SFR_WDATA[sct_pkg::CTL_FLAG]) |=> flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("event flag dropped");

	property p_code_stable;
		flag_r && $past(flag_r) |-> $stable(code_r);
	endproperty
	a_code_stable: assert property (p_code_stable) else $error("code moved while flagged");

	property p_slave_stop;
		slv_stop |=> SLAVE_RELEASE && !STOP_REQ && mode_r == sct_pkg::M_IDLE;
	endproperty
	a_slave_stop: assert property (p_slave_stop) else $error("slave stop not released");

	property p_ack_flag;
		ctl_wr |=> ACK_ASSERT == $past(SFR_WDATA[sct_pkg::CTL_ACK]);
	endproperty
	a_ack_flag: assert property (p_ack_flag) else $error("ack output mismatch");
endmodule : sct_tracker
